// file: design/ocm_pair_if.sv
interface ocm_pair_if;
    logic [1:0] sel_even;
    logic [1:0] sel_odd;
    logic [2:0] mode;
    logic       gp_even;
    logic       hp_even;
    logic       gp_odd;
    logic       hp_odd;
    logic       pin_even;
    logic       pin_odd;
    logic       en_even;
    logic       en_odd;
    logic       diff;
    logic       hcsl;

    // Register side drives selection and sources
    modport ctrl (
        output sel_even, sel_odd, mode, gp_even, hp_even, gp_odd, hp_odd,
        input  pin_even, pin_odd, en_even, en_odd, diff, hcsl
    );

    // Selector side drives the pins
    modport mux (
        input  sel_even, sel_odd, mode, gp_even, hp_even, gp_odd, hp_odd,
        output pin_even, pin_odd, en_even, en_odd, diff, hcsl
    );
endinterface : ocm_pair_if

// file: design/ocm_pair_mux.sv
module ocm_pair_mux (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Selection and pins of one output pair
    ocm_pair_if.mux   pair
);

    ocm_pkg::ocm_pair_state_type st_ff;
    ocm_pkg::ocm_pair_state_type nxt_st;

    // Reserved select codes give a quiet low level
    function automatic logic ocm_pick(input logic [1:0] sel, input logic gp, input logic hp);
        logic r;
        r = 1'b0;
        if (sel == ocm_pkg::OCM_SEL_GP) begin
            r = gp;
        end else if (sel == ocm_pkg::OCM_SEL_HP) begin
            r = hp;
        end
        return r;
    endfunction : ocm_pick

    // Next pin levels and enables
    always_comb begin
        logic paired;
        paired   = 1'b0;
        nxt_st   = st_ff;
        paired   = (pair.mode == ocm_pkg::OCM_MODE_COMPL) || (pair.mode == ocm_pkg::OCM_MODE_HCSL) ||
                   (pair.mode == ocm_pkg::OCM_MODE_PECL);
        nxt_st.pin_even = ocm_pick(pair.sel_even, pair.gp_even, pair.hp_even);
        if (paired) begin
            nxt_st.pin_odd = !nxt_st.pin_even;
        end else begin
            nxt_st.pin_odd = ocm_pick(pair.sel_odd, pair.gp_odd, pair.hp_odd);
        end
        nxt_st.en_even = paired || (pair.mode == ocm_pkg::OCM_MODE_CMOS_EVEN) ||
                         (pair.mode == ocm_pkg::OCM_MODE_CMOS_BOTH);
        nxt_st.en_odd  = paired || (pair.mode == ocm_pkg::OCM_MODE_CMOS_ODD) ||
                         (pair.mode == ocm_pkg::OCM_MODE_CMOS_BOTH);
        nxt_st.diff    = (pair.mode == ocm_pkg::OCM_MODE_HCSL) || (pair.mode == ocm_pkg::OCM_MODE_PECL);
        nxt_st.hcsl    = (pair.mode == ocm_pkg::OCM_MODE_HCSL);
    end

    // State register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Registered outputs
    assign pair.pin_even = st_ff.pin_even;
    assign pair.pin_odd  = st_ff.pin_odd;
    assign pair.en_even  = st_ff.en_even;
    assign pair.en_odd   = st_ff.en_odd;
    assign pair.diff     = st_ff.diff;
    assign pair.hcsl     = st_ff.hcsl;

    // Off mode leaves both pins undriven
    pair_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
        (pair.mode == ocm_pkg::OCM_MODE_OFF) |=> (!st_ff.en_even && !st_ff.en_odd))
        else $error("pair enabled in off mode");

endmodule : ocm_pair_mux

// file: design/ocm_pkg.sv
package ocm_pkg;

    // Register indices; the byte address is four times the index
    localparam logic [7:0] OCM_IDX_MODE_UPPER = 8'hb2;
    localparam logic [7:0] OCM_IDX_MODE_LOWER = 8'hb3;
    localparam logic [7:0] OCM_IDX_SEL_UPPER  = 8'hb4;
    localparam logic [7:0] OCM_IDX_SEL_LOWER  = 8'hb5;

    // Bus address layout
    localparam int         OCM_ADR_W          = 12;
    localparam int         OCM_IDX_LSB        = 2;
    localparam int         OCM_IDX_W          = 8;
    localparam logic [1:0] OCM_ADR_TOP_ZERO   = 2'h0;

    // Reset values
    localparam logic [7:0] OCM_SEL_UPPER_RST  = 8'h00;
    localparam logic [7:0] OCM_SEL_LOWER_RST  = 8'h00;
    localparam logic [7:0] OCM_MODE_UPPER_RST = 8'h00;
    localparam logic [7:0] OCM_MODE_LOWER_RST = 8'h00;

    // Writable bits of a mode register; bits 3 and 7 are reserved
    localparam logic [7:0] OCM_MODE_WR_MASK   = 8'h77;

    // Field positions inside a select or mode register
    localparam int         OCM_PAIR_SHIFT     = 4;
    localparam int         OCM_SEL_W          = 2;
    localparam int         OCM_ODD_SEL_LSB    = 2;
    localparam int         OCM_MODE_W         = 3;

    // Select field encodings
    localparam logic [1:0] OCM_SEL_GP         = 2'h0;
    localparam logic [1:0] OCM_SEL_HP         = 2'h1;

    // Pair mode encodings
    localparam logic [2:0] OCM_MODE_OFF       = 3'h0;
    localparam logic [2:0] OCM_MODE_CMOS_EVEN = 3'h1;
    localparam logic [2:0] OCM_MODE_CMOS_ODD  = 3'h2;
    localparam logic [2:0] OCM_MODE_CMOS_BOTH = 3'h3;
    localparam logic [2:0] OCM_MODE_COMPL     = 3'h4;
    localparam logic [2:0] OCM_MODE_HCSL      = 3'h5;
    localparam logic [2:0] OCM_MODE_PECL      = 3'h6;

    // Source clock positions in the synchroniser vector
    localparam int         OCM_NSRC           = 6;
    localparam int         OCM_SRC_GP_A       = 0;
    localparam int         OCM_SRC_GP_B       = 1;
    localparam int         OCM_SRC_GP_C       = 2;
    localparam int         OCM_SRC_GP_D       = 3;
    localparam int         OCM_SRC_HP_C       = 4;
    localparam int         OCM_SRC_HP_D       = 5;

    // Per output: source for select 00 and for select 01
    localparam int OCM_GP_IDX [8] = '{OCM_SRC_GP_A, OCM_SRC_GP_B, OCM_SRC_GP_C, OCM_SRC_GP_D,
                                      OCM_SRC_GP_A, OCM_SRC_GP_C, OCM_SRC_GP_A, OCM_SRC_GP_D};
    localparam int OCM_HP_IDX [8] = '{OCM_SRC_HP_C, OCM_SRC_HP_C, OCM_SRC_HP_D, OCM_SRC_HP_D,
                                      OCM_SRC_HP_C, OCM_SRC_HP_D, OCM_SRC_HP_C, OCM_SRC_HP_D};

    // Top-level state
    typedef struct packed {
        logic [OCM_NSRC-1:0] sync1;
        logic [OCM_NSRC-1:0] sync2;
        logic [7:0]          sel_upper;
        logic [7:0]          sel_lower;
        logic [7:0]          mode_upper;
        logic [7:0]          mode_lower;
        logic                ack;
        logic [7:0]          rdat;
    } ocm_top_state_type;

    localparam ocm_top_state_type OCM_TOP_RST = '{
        sync1      : '0,
        sync2      : '0,
        sel_upper  : OCM_SEL_UPPER_RST,
        sel_lower  : OCM_SEL_LOWER_RST,
        mode_upper : OCM_MODE_UPPER_RST,
        mode_lower : OCM_MODE_LOWER_RST,
        ack        : 1'b0,
        rdat       : 8'h00
    };

    // Pair selector state
    typedef struct packed {
        logic pin_even;
        logic pin_odd;
        logic en_even;
        logic en_odd;
        logic diff;
        logic hcsl;
    } ocm_pair_state_type;

endpackage : ocm_pkg

// file: design/ocm_top.sv
// Operation
// - Output 4 follows upper select bits 1:0 in every mode: 00 general divider A, 01 fast divider C.
// - Output 5 single-ended follows upper select bits 3:2: 00 general divider C, 01 fast divider D.
// - With pair 4/5 in a differential mode, output 5 ignores its field and carries the inverse of output 4.
// - Output 6 follows upper select bits 5:4 in every mode: 00 general divider A, 01 fast divider C.
// - Output 7 single-ended follows upper select bits 7:6: 00 general divider D, 01 fast divider D.
// - With pair 6/7 in a differential mode, output 7 ignores its field and carries the inverse of output 6.
// - Output 0 follows lower select bits 1:0 in every mode: 00 general divider A, 01 fast divider C.
// - Output 1 single-ended follows lower select bits 3:2: 00 general divider B, 01 fast divider C.
// - With pair 0/1 in a differential mode, output 1 ignores its field and carries the inverse of output 0.
// - Output 2 follows lower select bits 5:4 in every mode: 00 general divider C, 01 fast divider D.
// - Each pair has a three-bit mode: 000 off, 001 to 011 single-ended, 100 complementary, 101 HCSL, 110 PECL.
// - Output 3 single-ended follows lower select bits 7:6, 00 general D, 01 fast D; paired it inverts output 2.
//
// The Wishbone interface to the registers is this design's own decision.
module ocm_top (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [11:0] wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Synthesizer divider clocks
    input  wire logic        gp_synth_div_a,
    input  wire logic        gp_synth_div_b,
    input  wire logic        gp_synth_div_c,
    input  wire logic        gp_synth_div_d,
    input  wire logic        hp_synth_div_c,
    input  wire logic        hp_synth_div_d,
    // Configurable clock outputs
    output logic             cfg_clock_pin_0_o,
    output logic             cfg_clock_pin_1_o,
    output logic             cfg_clock_pin_2_o,
    output logic             cfg_clock_pin_3_o,
    output logic             cfg_clock_pin_4_o,
    output logic             cfg_clock_pin_5_o,
    output logic             cfg_clock_pin_6_o,
    output logic             cfg_clock_pin_7_o,
    // Output enables and pair driver kind
    output logic      [7:0]  cfg_clock_en_o,
    output logic      [3:0]  cfg_pair_diff_o,
    output logic      [3:0]  cfg_pair_hcsl_o
);

    ocm_pkg::ocm_top_state_type st_ff;
    ocm_pkg::ocm_top_state_type nxt_st;

    logic [ocm_pkg::OCM_NSRC-1:0]  src_raw;
    logic                          bus_req;
    logic                          bus_wr;
    logic                          adr_ok;
    logic [ocm_pkg::OCM_IDX_W-1:0] reg_idx;
    logic [7:0]                    pin_vec;
    logic [7:0]                    en_vec;
    logic [3:0]                    diff_vec;
    logic [3:0]                    hcsl_vec;

    // Gather divider clocks in synchroniser order
    assign src_raw = {hp_synth_div_d, hp_synth_div_c, gp_synth_div_d,
                      gp_synth_div_c, gp_synth_div_b, gp_synth_div_a};

    // Bus decode; a request is taken once, ack drops the next cycle
    assign bus_req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign bus_wr  = bus_req && wb_we_i && wb_sel_i[0];
    assign adr_ok  = (wb_adr_i[ocm_pkg::OCM_ADR_W-1:ocm_pkg::OCM_IDX_LSB+ocm_pkg::OCM_IDX_W]
                      == ocm_pkg::OCM_ADR_TOP_ZERO);
    assign reg_idx = wb_adr_i[ocm_pkg::OCM_IDX_LSB +: ocm_pkg::OCM_IDX_W];

    // Synchronisers, register writes and read data
    always_comb begin
        nxt_st       = st_ff;
        nxt_st.sync1 = src_raw;
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.ack   = bus_req;
        nxt_st.rdat  = 8'h00;
        if (bus_req && adr_ok) begin
            case (reg_idx)
                ocm_pkg::OCM_IDX_MODE_UPPER: begin
                    nxt_st.rdat = st_ff.mode_upper;
                    if (bus_wr) begin
                        nxt_st.mode_upper = wb_dat_i[7:0] & ocm_pkg::OCM_MODE_WR_MASK;
                    end
                end
                ocm_pkg::OCM_IDX_MODE_LOWER: begin
                    nxt_st.rdat = st_ff.mode_lower;
                    if (bus_wr) begin
                        nxt_st.mode_lower = wb_dat_i[7:0] & ocm_pkg::OCM_MODE_WR_MASK;
                    end
                end
                ocm_pkg::OCM_IDX_SEL_UPPER: begin
                    nxt_st.rdat = st_ff.sel_upper;
                    if (bus_wr) begin
                        nxt_st.sel_upper = wb_dat_i[7:0];
                    end
                end
                ocm_pkg::OCM_IDX_SEL_LOWER: begin
                    nxt_st.rdat = st_ff.sel_lower;
                    if (bus_wr) begin
                        nxt_st.sel_lower = wb_dat_i[7:0];
                    end
                end
                default: begin
                    nxt_st.rdat = 8'h00;
                end
            endcase
        end
    end

    // State register with reset to zero selections
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= ocm_pkg::OCM_TOP_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Bus outputs
    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = {24'h000000, st_ff.rdat};

    // One selector per output pair
    for (genvar p = 0; p < 4; p++) begin : g_pair
        localparam int EVN = 2 * p;
        localparam int ODD = 2 * p + 1;
        localparam int SH  = (p % 2) * ocm_pkg::OCM_PAIR_SHIFT;
        logic [7:0] sel_reg;
        logic [7:0] mode_reg;
        ocm_pair_if pif ();

        // Lower registers serve pairs 0 and 1, upper ones pairs 2 and 3
        assign sel_reg      = (p < 2) ? st_ff.sel_lower : st_ff.sel_upper;
        assign mode_reg     = (p < 2) ? st_ff.mode_lower : st_ff.mode_upper;
        assign pif.sel_even = sel_reg[SH +: ocm_pkg::OCM_SEL_W];
        assign pif.sel_odd  = sel_reg[SH + ocm_pkg::OCM_ODD_SEL_LSB +: ocm_pkg::OCM_SEL_W];
        assign pif.mode     = mode_reg[SH +: ocm_pkg::OCM_MODE_W];
        assign pif.gp_even  = st_ff.sync2[ocm_pkg::OCM_GP_IDX[EVN]];
        assign pif.hp_even  = st_ff.sync2[ocm_pkg::OCM_HP_IDX[EVN]];
        assign pif.gp_odd   = st_ff.sync2[ocm_pkg::OCM_GP_IDX[ODD]];
        assign pif.hp_odd   = st_ff.sync2[ocm_pkg::OCM_HP_IDX[ODD]];

        ocm_pair_mux u_mux (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .pair  (pif.mux)
        );

        // Collect pair results
        assign pin_vec[EVN] = pif.pin_even;
        assign pin_vec[ODD] = pif.pin_odd;
        assign en_vec[EVN]  = pif.en_even;
        assign en_vec[ODD]  = pif.en_odd;
        assign diff_vec[p]  = pif.diff;
        assign hcsl_vec[p]  = pif.hcsl;
    end

    // Pin outputs
    assign cfg_clock_pin_0_o = pin_vec[0];
    assign cfg_clock_pin_1_o = pin_vec[1];
    assign cfg_clock_pin_2_o = pin_vec[2];
    assign cfg_clock_pin_3_o = pin_vec[3];
    assign cfg_clock_pin_4_o = pin_vec[4];
    assign cfg_clock_pin_5_o = pin_vec[5];
    assign cfg_clock_pin_6_o = pin_vec[6];
    assign cfg_clock_pin_7_o = pin_vec[7];
    assign cfg_clock_en_o    = en_vec;
    assign cfg_pair_diff_o   = diff_vec;
    assign cfg_pair_hcsl_o   = hcsl_vec;

    // Checks of routing, pairing and register behaviour
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    out4_route_a: assert property (
        (st_ff.sel_upper[1:0] == 2'h1) |=> (cfg_clock_pin_4_o == $past(st_ff.sync2[4])))
        else $error("output 4 not fed from fast divider C");

    out5_route_a: assert property (
        (st_ff.sel_upper[3:2] == 2'h0 && st_ff.mode_upper[2:0] == 3'h3)
        |=> (cfg_clock_pin_5_o == $past(st_ff.sync2[2])))
        else $error("output 5 not fed from general divider C");

    pair45_inv_a: assert property (
        (st_ff.mode_upper[2:0] inside {3'h4, 3'h5, 3'h6}) |=> (cfg_clock_pin_5_o != cfg_clock_pin_4_o))
        else $error("output 5 not inverse of output 4");

    out6_route_a: assert property (
        (st_ff.sel_upper[5:4] == 2'h0) |=> (cfg_clock_pin_6_o == $past(st_ff.sync2[0])))
        else $error("output 6 not fed from general divider A");

    out7_route_a: assert property (
        (st_ff.sel_upper[7:6] == 2'h1 && st_ff.mode_upper[6:4] == 3'h2)
        |=> (cfg_clock_pin_7_o == $past(st_ff.sync2[5])))
        else $error("output 7 not fed from fast divider D");

    pair67_inv_a: assert property (
        (st_ff.mode_upper[6:4] inside {3'h4, 3'h5, 3'h6}) |=> (cfg_clock_pin_7_o != cfg_clock_pin_6_o))
        else $error("output 7 not inverse of output 6");

    out0_route_a: assert property (
        (st_ff.sel_lower[1:0] == 2'h0) |=> (cfg_clock_pin_0_o == $past(st_ff.sync2[0])))
        else $error("output 0 not fed from general divider A");

    out1_route_a: assert property (
        (st_ff.sel_lower[3:2] == 2'h0 && st_ff.mode_lower[2:0] == 3'h1)
        |=> (cfg_clock_pin_1_o == $past(st_ff.sync2[1])))
        else $error("output 1 not fed from general divider B");

    pair01_inv_a: assert property (
        (st_ff.mode_lower[2:0] inside {3'h4, 3'h5, 3'h6}) |=> (cfg_clock_pin_1_o != cfg_clock_pin_0_o))
        else $error("output 1 not inverse of output 0");

    out2_route_a: assert property (
        (st_ff.sel_lower[5:4] == 2'h1) |=> (cfg_clock_pin_2_o == $past(st_ff.sync2[5])))
        else $error("output 2 not fed from fast divider D");

    out3_route_a: assert property (
        (st_ff.sel_lower[7:6] == 2'h0 && st_ff.mode_lower[6:4] == 3'h3)
        |=> (cfg_clock_pin_3_o == $past(st_ff.sync2[3])))
        else $error("output 3 not fed from general divider D");

    pair23_inv_a: assert property (
        (st_ff.mode_lower[6:4] inside {3'h4, 3'h5, 3'h6}) |=> (cfg_clock_pin_3_o != cfg_clock_pin_2_o))
        else $error("output 3 not inverse of output 2");

    out4_gen_a: assert property (
        (st_ff.sel_upper[1:0] == 2'h0) |=> (cfg_clock_pin_4_o == $past(st_ff.sync2[0])))
        else $error("output 4 not fed from general divider A");

    out5_fast_a: assert property (
        (st_ff.sel_upper[3:2] == 2'h1 && st_ff.mode_upper[2:0] inside {3'h1, 3'h2, 3'h3})
        |=> (cfg_clock_pin_5_o == $past(st_ff.sync2[5])))
        else $error("output 5 not fed from fast divider D");

    out6_fast_a: assert property (
        (st_ff.sel_upper[5:4] == 2'h1) |=> (cfg_clock_pin_6_o == $past(st_ff.sync2[4])))
        else $error("output 6 not fed from fast divider C");

    out7_gen_a: assert property (
        (st_ff.sel_upper[7:6] == 2'h0 && st_ff.mode_upper[6:4] inside {3'h1, 3'h2, 3'h3})
        |=> (cfg_clock_pin_7_o == $past(st_ff.sync2[3])))
        else $error("output 7 not fed from general divider D");

    out0_fast_a: assert property (
        (st_ff.sel_lower[1:0] == 2'h1) |=> (cfg_clock_pin_0_o == $past(st_ff.sync2[4])))
        else $error("output 0 not fed from fast divider C");

    out1_fast_a: assert property (
        (st_ff.sel_lower[3:2] == 2'h1 && st_ff.mode_lower[2:0] inside {3'h1, 3'h2, 3'h3})
        |=> (cfg_clock_pin_1_o == $past(st_ff.sync2[4])))
        else $error("output 1 not fed from fast divider C");

    out2_gen_a: assert property (
        (st_ff.sel_lower[5:4] == 2'h0) |=> (cfg_clock_pin_2_o == $past(st_ff.sync2[2])))
        else $error("output 2 not fed from general divider C");

    out3_fast_a: assert property (
        (st_ff.sel_lower[7:6] == 2'h1 && st_ff.mode_lower[6:4] inside {3'h1, 3'h2, 3'h3})
        |=> (cfg_clock_pin_3_o == $past(st_ff.sync2[5])))
        else $error("output 3 not fed from fast divider D");

    reserved_low_a: assert property (
        (st_ff.sel_upper[1] == 1'b1) |=> !cfg_clock_pin_4_o)
        else $error("reserved select did not give low");

    mode_enable_a: assert property (
        (st_ff.mode_lower[2:0] == 3'h5) |=> (cfg_clock_en_o[1:0] == 2'h3 && cfg_pair_hcsl_o[0]
                                              && cfg_pair_diff_o[0]))
        else $error("HCSL mode did not enable pair 0");

    cmos_single_a: assert property (
        (st_ff.mode_upper[6:4] == 3'h2) |=> (cfg_clock_en_o[7:6] == 2'h2 && !cfg_pair_diff_o[3]))
        else $error("single-ended enable wrong on pair 3");

    sel_write_a: assert property (
        (bus_wr && adr_ok && reg_idx == 8'hb5) |=> (st_ff.sel_lower == $past(wb_dat_i[7:0]) && wb_ack_o)
        ##1 (wb_dat_o[31:8] == 24'h000000))
        else $error("select write not applied");

    write_reaches_pin_a: assert property (
        (bus_wr && adr_ok && reg_idx == 8'hb4 && wb_dat_i[1:0] == 2'h0)
        |=> ##1 (cfg_clock_pin_4_o == $past(st_ff.sync2[0])))
        else $error("new selection not seen on output 4");

    bus_ack_a: assert property (
        bus_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not a single cycle");

    reset_sel_a: assert property (@(posedge clk_i) disable iff (1'b0)
        rst_i |=> (st_ff.sel_upper == 8'h00 && st_ff.sel_lower == 8'h00 && cfg_clock_en_o == 8'h00))
        else $error("select registers not cleared by reset");

    // Main scenarios
    diff_pair_c: cover property (
        (st_ff.mode_upper[2:0] == 3'h6) ##1 (cfg_clock_pin_4_o && !cfg_clock_pin_5_o));
    fast_route_c: cover property (
        (st_ff.sel_lower[1:0] == 2'h1) ##1 cfg_clock_pin_0_o ##1 !cfg_clock_pin_0_o);
    reg_read_c: cover property (
        (bus_req && !wb_we_i && reg_idx == 8'hb4) ##1 (wb_ack_o && wb_dat_o != 32'h00000000));
    single_both_c: cover property (
        (st_ff.mode_lower[6:4] == 3'h3) ##1 (cfg_clock_en_o[3:2] == 2'h3));

endmodule : ocm_top

// file: test/ocm_top_tb.sv
module ocm_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
        $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
    // Source index of select 00 and 01 per output
    localparam int GP [8] = '{0, 1, 2, 3, 0, 2, 0, 3};
    localparam int HP [8] = '{4, 4, 5, 5, 4, 5, 4, 5};
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic [3:0]  wb_sel_i = 4'h0, diff_o, hcsl_o;
    logic [5:0]  src = 6'h00;
    logic [7:0]  pins, en_o, su, sl, mu, ml, ep;
    int          bad_count = 0, n_checks = 0, seed = 10;
    logic        ack_o;
    ocm_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_dat_o(wb_dat_o), .wb_ack_o(ack_o),
        .gp_synth_div_a(src[0]), .gp_synth_div_b(src[1]), .gp_synth_div_c(src[2]), .gp_synth_div_d(src[3]),
        .hp_synth_div_c(src[4]), .hp_synth_div_d(src[5]), .cfg_clock_pin_0_o(pins[0]),
        .cfg_clock_pin_1_o(pins[1]), .cfg_clock_pin_2_o(pins[2]), .cfg_clock_pin_3_o(pins[3]),
        .cfg_clock_pin_4_o(pins[4]), .cfg_clock_pin_5_o(pins[5]), .cfg_clock_pin_6_o(pins[6]),
        .cfg_clock_pin_7_o(pins[7]), .cfg_clock_en_o(en_o), .cfg_pair_diff_o(diff_o), .cfg_pair_hcsl_o(hcsl_o));
    // 20 MHz clock
    always #25 clk_i = ~clk_i;
    // One classic cycle, held until ack is sampled
    task automatic bus(input logic [11:0] adr, input logic we, input logic [7:0] d, input logic [3:0] be);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, d};
        wb_sel_i <= be;
        // Wait for ack with no cycle limit; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : bus
    // Expected routed level per output
    function automatic logic [7:0] exp_pins(input logic [15:0] sel, input logic [15:0] md, input logic [5:0] s);
        logic [7:0] p;
        logic [2:0] m;
        for (int n = 0; n < 8; n++) begin
            m = md[4*(n/2) +: 3];
            if (n % 2 == 1 && m inside {3'h4, 3'h5, 3'h6}) p[n] = ~p[n-1];
            else p[n] = (sel[2*n +: 2] == 2'h0) ? s[GP[n]] : (sel[2*n +: 2] == 2'h1) ? s[HP[n]] : 1'b0;
        end
        return p;
    endfunction : exp_pins
    // Expected {hcsl, diff, enables}
    function automatic logic [15:0] exp_drv(input logic [15:0] md);
        logic [15:0] r;
        logic [2:0]  m;
        r = 16'h0;
        for (int q = 0; q < 4; q++) begin
            m = md[4*q +: 3];
            r[2*q +: 2] = (m == 3'h1) ? 2'h1 : (m == 3'h2) ? 2'h2 : (m inside {[3'h3:3'h6]}) ? 2'h3 : 2'h0;
            r[8+q] = (m == 3'h5 || m == 3'h6);
            r[12+q] = (m == 3'h5);
        end
        return r;
    endfunction : exp_drv
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : end_sim
    // Watchdog
    initial begin
        #1000000;
        bad_count++;
        end_sim();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 4; a++) begin
            bus({2'h0, 8'hb2 + 8'(a), 2'h0}, 1'b0, 8'h00, 4'hf);
            `CHK(rd, 32'h0)
        end
        `CHK(pins, 8'h00)
        $display("test reset done");
        for (int i = 0; i < 40; i++) begin
            {su, sl, mu, ml} = $random(seed);
            if (i < 4) {su, sl} = (i % 2) ? 16'hffff : 16'h5555;
            if (i < 4) {mu, ml} = 16'h6655 + 16'(i * 16'h1111);
            bus(12'h2c8, 1'b1, mu, 4'h1);
            bus(12'h2cc, 1'b1, ml, 4'h1);
            bus(12'h2d0, 1'b1, su, 4'h1);
            bus(12'h2d4, 1'b1, sl, 4'h1);
            bus(12'h2d0, 1'b0, 8'h00, 4'hf);
            `CHK(rd, {24'h0, su})
            bus(12'h2c8, 1'b0, 8'h00, 4'hf);
            `CHK(rd, {24'h0, mu & 8'h77})
            // All six divider inputs, general and fast alike, take new random static levels
            src <= 6'($random(seed));
            repeat (5) @(posedge clk_i);
            ep = exp_pins({su, sl}, {mu, ml} & 16'h7777, src);
            `CHK(pins[7:4], ep[7:4])
            `CHK(pins[3:0], ep[3:0])
            `CHK({hcsl_o, diff_o, en_o}, exp_drv({mu, ml} & 16'h7777))
        end
        $display("test routing done");
        bus(12'h2d4, 1'b1, ~sl, 4'he);
        bus(12'h6d4, 1'b1, ~sl, 4'h1);
        bus(12'h2d4, 1'b0, 8'h00, 4'hf);
        `CHK(rd, {24'h0, sl})
        bus(12'h2d8, 1'b0, 8'h00, 4'hf);
        `CHK(rd, 32'h0)
        $display("test refusals done");
        end_sim();
    end
endmodule : ocm_top_tb
